// [rtl/clfr_pkg.sv]
package clfr_pkg;

	// Link geometry
	localparam int LINK_BITS      = 28;
	localparam int PORT_BITS      = 8;
	localparam int NUM_PORTS      = 8;
	localparam int PORTS_PER_LINK = 3;

	// Serial timing
	localparam int CLK_HZ        = 100_000_000;
	localparam int BAUD_DEFAULT  = 9600;
	localparam int BAUD_DIV      = CLK_HZ / BAUD_DEFAULT;
	localparam int SER_DATA_BITS = 8;

	// Counter widths and reset values
	localparam int CNT_W              = 16;
	localparam logic [3:0] CC_RST_VAL = 4'h8;

	typedef enum logic [1:0] {
		CLFR_BASE,
		CLFR_MEDIUM,
		CLFR_FULL
	} clfr_cfg_e;

	// Enables of one serializer link
	typedef struct packed {
		logic spare;
		logic dval;
		logic lval;
		logic fval;
	} clfr_en_s;

	// Captured pixel word with its position
	typedef struct packed {
		logic [NUM_PORTS*PORT_BITS-1:0] pix;
		logic [CNT_W-1:0]               x;
		logic [CNT_W-1:0]               y;
		logic                           sof;
	} clfr_pix_s;

endpackage : clfr_pkg

// [rtl/clfr_uart.sv]
`timescale 1ns/1ps
module clfr_uart
	import clfr_pkg::*;
#(
	parameter int DIV = BAUD_DIV
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// Transmit side
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_busy,
	output logic            tx_line,
	// Receive side (line already synchronised)
	input  wire logic       rx_line,
	output logic            rx_valid,
	output logic [7:0]      rx_data
);

	logic [15:0] tx_cnt_q;
	logic [3:0]  tx_bit_q;
	logic [9:0]  tx_sh_q;
	logic [15:0] rx_cnt_q;
	logic [3:0]  rx_bit_q;
	logic [7:0]  rx_sh_q;
	logic        rx_act_q;

	// Transmitter: start, eight data bits LSB first, stop; no parity
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_cnt_q <= 16'h0000;
			tx_bit_q <= 4'h0;
			tx_sh_q  <= 10'h3FF;
			tx_busy  <= 1'b0;
			tx_line  <= 1'b1;
		end else if (ce) begin
			if (!tx_busy) begin
				if (tx_valid) begin
					tx_sh_q  <= {1'b1, tx_data, 1'b0};
					tx_busy  <= 1'b1;
					tx_bit_q <= 4'h0;
					tx_cnt_q <= 16'h0000;
					tx_line  <= 1'b0;
				end
			end else if (tx_cnt_q == 16'(DIV - 1)) begin
				tx_cnt_q <= 16'h0000;
				if (tx_bit_q == 4'h9) begin
					tx_busy <= 1'b0;
					tx_line <= 1'b1;
				end else begin
					tx_bit_q <= tx_bit_q + 4'h1;
					tx_line  <= tx_sh_q[tx_bit_q + 4'h1];
				end
			end else begin
				tx_cnt_q <= tx_cnt_q + 16'h0001;
			end
		end
	end

	// Receiver: samples mid-bit, drops a character without a stop bit
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 4'h0;
			rx_sh_q  <= 8'h00;
			rx_act_q <= 1'b0;
			rx_valid <= 1'b0;
			rx_data  <= 8'h00;
		end else if (ce) begin
			rx_valid <= 1'b0;
			if (!rx_act_q) begin
				if (!rx_line) begin
					rx_act_q <= 1'b1;
					rx_bit_q <= 4'h0;
					rx_cnt_q <= 16'(DIV / 2);
				end
			end else if (rx_cnt_q == 16'(DIV - 1)) begin
				rx_cnt_q <= 16'h0000;
				if (rx_bit_q == 4'h0 && rx_line) begin
					rx_act_q <= 1'b0; // False start
				end else if (rx_bit_q == 4'h9) begin
					rx_act_q <= 1'b0;
					if (rx_line) begin
						rx_valid <= 1'b1;
						rx_data  <= rx_sh_q;
					end
				end else begin
					if (rx_bit_q != 4'h0) begin
						rx_sh_q <= {rx_line, rx_sh_q[7:1]};
					end
					rx_bit_q <= rx_bit_q + 4'h1;
				end
			end else begin
				rx_cnt_q <= rx_cnt_q + 16'h0001;
			end
		end
	end

endmodule : clfr_uart

// [rtl/clfr_receiver.sv]
`timescale 1ns/1ps
module clfr_receiver
	import clfr_pkg::*;
#(
	parameter int DIV = BAUD_DIV
) (
	// System clock domain
	input  wire logic                         clock,
	input  wire logic                         rst_n,
	input  wire logic                         ce,
	input  wire clfr_cfg_e                    cfg,
	// Pixel link domain
	input  wire logic                         pix_clock,
	input  wire logic [3*LINK_BITS-1:0]       link_bits,
	// Camera control sources
	input  wire logic                         exposure_sync_pulse,
	input  wire logic                         pixel_reset_signal,
	input  wire logic                         forward_dir,
	input  wire logic                         cc_override,
	input  wire logic [3:0]                   cc_user,
	output logic [3:0]                        cc_out,
	// Serial channel
	input  wire logic                         ser_tfg,
	output logic                              ser_tc,
	input  wire logic                         tx_valid,
	input  wire logic [7:0]                   tx_data,
	output logic                              tx_busy,
	output logic                              rx_valid,
	output logic [7:0]                        rx_data,
	// Captured pixels, system domain
	output logic                              pix_valid,
	output clfr_pix_s                         pix_word,
	output logic [CNT_W-1:0]                  line_pixels,
	output logic [CNT_W-1:0]                  frame_lines
);

	// Link domain: reset released through the link clock
	logic       lrst_a_q, lrst_n_q;
	always_ff @(posedge pix_clock or negedge rst_n) begin
		if (!rst_n) begin
			lrst_a_q <= 1'b0;
			lrst_n_q <= 1'b0;
		end else begin
			lrst_a_q <= 1'b1;
			lrst_n_q <= lrst_a_q;
		end
	end

	// Split links into 24 data bits each; the four enables are taken from link 0 only
	clfr_en_s                        en0;
	logic [NUM_PORTS*PORT_BITS-1:0]  ports;
	logic [3*PORTS_PER_LINK*PORT_BITS-1:0] raw;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_link
			assign raw[g*24 +: 24] = link_bits[g*LINK_BITS +: 24];
		end
	endgenerate
	assign en0 = clfr_en_s'(link_bits[24 +: 4]); // Link 0 enables govern all

	// Ports beyond the configured links read as zero
	always_comb begin
		ports = raw[NUM_PORTS*PORT_BITS-1:0];
		unique case (cfg)
			CLFR_BASE:   ports[63:24] = 40'h0; // Ports A-C
			CLFR_MEDIUM: ports[63:48] = 16'h0; // Ports A-F
			default:     ports = raw[63:0]; // Ports A-H
		endcase
	end

	// Link-domain capture and counting
	logic                            lv_d1_q;
	logic [CNT_W-1:0]                xc_q, yc_q, lp_q, fl_q;
	logic                            sof_pend_q, ltgl_q;
	clfr_pix_s                       lw_q;
	logic                            qual;
	assign qual = en0.fval & en0.lval & en0.dval;

	always_ff @(posedge pix_clock or negedge lrst_n_q) begin
		if (!lrst_n_q) begin
			lv_d1_q    <= 1'b0;
			xc_q       <= '0;
			yc_q       <= '0;
			lp_q       <= '0;
			fl_q       <= '0;
			sof_pend_q <= 1'b0;
			ltgl_q     <= 1'b0;
			lw_q       <= '0;
		end else begin
			lv_d1_q <= en0.lval;
			if (!en0.fval) begin
				if (yc_q != '0) fl_q <= yc_q; // Frame ended
				yc_q       <= '0;
				sof_pend_q <= 1'b1;
			end else if (en0.lval && !lv_d1_q) begin
				yc_q <= yc_q + 1'b1; // Line rising edge
			end
			if (!en0.lval) begin
				if (lv_d1_q) lp_q <= xc_q; // Line ended
				xc_q <= '0;
			end else if (qual) begin
				xc_q <= xc_q + 1'b1;
			end
			if (qual) begin
				lw_q.pix   <= ports;
				lw_q.x     <= xc_q;
				lw_q.y     <= (en0.lval && !lv_d1_q) ? yc_q : yc_q - 1'b1;
				lw_q.sof   <= sof_pend_q;
				sof_pend_q <= 1'b0;
				ltgl_q     <= ~ltgl_q;
			end
		end
	end

	// Link-domain checks
	sequence s_gap;
		!en0.fval;
	endsequence
	sequence s_take;
		qual;
	endsequence
	sequence s_first;
		qual && sof_pend_q;
	endsequence
	a_cap_qual: assert property (@(posedge pix_clock) disable iff (!lrst_n_q)
		!qual |=> $stable(ltgl_q)) else $error("capture without qual");
	a_cap_take: assert property (@(posedge pix_clock) disable iff (!lrst_n_q)
		s_take |=> ltgl_q != $past(ltgl_q)) else $error("qualified word lost");
	a_xcount: assert property (@(posedge pix_clock) disable iff (!lrst_n_q)
		s_take |=> xc_q == $past(xc_q) + 1'b1) else $error("pixel count");
	a_ycount: assert property (@(posedge pix_clock) disable iff (!lrst_n_q)
		en0.fval && en0.lval && !lv_d1_q |=> yc_q == $past(yc_q) + 1'b1)
		else $error("line count");
	a_sof_arm: assert property (@(posedge pix_clock) disable iff (!lrst_n_q)
		s_gap |=> sof_pend_q) else $error("frame start not armed");
	a_sof_mark: assert property (@(posedge pix_clock) disable iff (!lrst_n_q)
		s_first |=> lw_q.sof && !sof_pend_q) else $error("frame start not marked");
	a_base_zero: assert property (@(posedge pix_clock) disable iff (!lrst_n_q)
		cfg == CLFR_BASE && qual |=> lw_q.pix[63:24] == '0) else $error("base ports");

	// Toggle handshake into the system domain; the pixel clock is slower
	logic [2:0]         tsync_q;
	logic [2*CNT_W-1:0] cnt_s1_q, cnt_s2_q, cnt_s3_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tsync_q     <= 3'h0;
			pix_valid   <= 1'b0;
			pix_word    <= '0;
			cnt_s1_q    <= '0;
			cnt_s2_q    <= '0;
			cnt_s3_q    <= '0;
			line_pixels <= '0;
			frame_lines <= '0;
		end else if (ce) begin
			tsync_q   <= {tsync_q[1:0], ltgl_q};
			pix_valid <= tsync_q[2] ^ tsync_q[1];
			if (tsync_q[2] ^ tsync_q[1]) pix_word <= lw_q;
			cnt_s1_q <= {lp_q, fl_q};
			cnt_s2_q <= cnt_s1_q;
			cnt_s3_q <= cnt_s2_q;
			if (cnt_s3_q == cnt_s2_q) begin
				line_pixels <= cnt_s3_q[2*CNT_W-1:CNT_W]; // Stable counts only
				frame_lines <= cnt_s3_q[CNT_W-1:0];
			end
		end
	end

	// Camera control outputs, default mapping unless overridden
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cc_out <= CC_RST_VAL;
		end else if (ce) begin
			if (cc_override) cc_out <= cc_user;
			else cc_out <= {1'b1, forward_dir, pixel_reset_signal,
				exposure_sync_pulse};
		end
	end

	// Camera control checks
	a_cc4_high: assert property (@(posedge clock) disable iff (!rst_n)
		ce && !cc_override |=> cc_out[3]) else $error("cc4 not high");
	a_cc1_map: assert property (@(posedge clock) disable iff (!rst_n)
		ce && !cc_override |=> cc_out[0] == $past(exposure_sync_pulse))
		else $error("cc1 mapping");
	a_cc_rest: assert property (@(posedge clock) disable iff (!rst_n)
		ce && !cc_override |=> cc_out[1] == $past(pixel_reset_signal)
		&& cc_out[2] == $past(forward_dir))
		else $error("cc2 cc3 mapping");
	a_cc_user: assert property (@(posedge clock) disable iff (!rst_n)
		ce && cc_override |=> cc_out == $past(cc_user)) else $error("cc override");
	a_cc_hold: assert property (@(posedge clock) disable iff (!rst_n)
		!ce |=> $stable(cc_out)) else $error("cc moved while frozen");

	// Serial receive line synchroniser
	logic [1:0] rxs_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) rxs_q <= 2'h3;
		else if (ce) rxs_q <= {rxs_q[0], ser_tfg};
	end

	// Serial channel at the configured rate
	clfr_uart #(.DIV(DIV)) u_uart (
		.clock    (clock),
		.rst_n    (rst_n),
		.ce       (ce),
		.tx_valid (tx_valid),
		.tx_data  (tx_data),
		.tx_busy  (tx_busy),
		.tx_line  (ser_tc),
		.rx_line  (rxs_q[1]),
		.rx_valid (rx_valid),
		.rx_data  (rx_data)
	);

	// Serial transmit checks
	sequence s_start;
		ce && tx_valid && !tx_busy;
	endsequence
	a_tx_start: assert property (@(posedge clock) disable iff (!rst_n)
		s_start |=> !ser_tc && tx_busy) else $error("no start bit");
	a_tx_idle: assert property (@(posedge clock) disable iff (!rst_n)
		!tx_busy |-> ser_tc) else $error("line not idle high");

endmodule : clfr_receiver

// [verification/clfr_camera.sv]
`timescale 1ns/1ps
module clfr_camera
	import clfr_pkg::*;
#(
	parameter int BIT_NS = 80
) (
	// Link side
	input  wire logic                   pix_clock,
	output logic [3*LINK_BITS-1:0]      link_bits,
	// Serial lines
	input  wire logic                   ser_tc,
	output logic                        ser_tfg
);
	// Idle link and idle serial line
	initial begin
		link_bits = '0;
		ser_tfg = 1'b1;
	end
	// One pixel clock; every link carries the same enables, no bit left floating
	task automatic beat(input logic [3:0] en, input logic [23:0] px);
		@(negedge pix_clock);
		link_bits = {3{en, px}};
	endtask : beat
	// One line of n pixels, with a stall cycle after the first pixel
	task automatic line(input int n, input logic [23:0] base);
		beat(4'h1, 24'h000000);
		for (int i = 0; i < n; i++) begin
			beat(4'h7, base + 24'(i));
			if (i == 0) beat(4'h3, 24'hFFFFFF);
		end
		beat(4'h1, 24'h000000);
	endtask : line
	// Character to the grabber: start, eight bits LSB first, stop
	task automatic send(input logic [7:0] b);
		ser_tfg = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < 8; i++) begin
			ser_tfg = b[i];
			#(BIT_NS);
		end
		ser_tfg = 1'b1;
		#(BIT_NS);
	endtask : send
	// Character from the grabber, sampled mid-bit
	task automatic recv(output logic [7:0] b);
		@(negedge ser_tc);
		#(BIT_NS * 3 / 2);
		for (int i = 0; i < 8; i++) begin
			b[i] = ser_tc;
			#(BIT_NS);
		end
	endtask : recv
endmodule : clfr_camera

// [verification/camlink_frame_receiver_bench.sv]
`timescale 1ns/1ps
module camlink_frame_receiver_bench;
	import clfr_pkg::*;
	logic              clock = 0, rst_n = 1, ce = 1, pix_clock = 0;
	clfr_cfg_e         cfg = CLFR_BASE;
	logic [83:0]       link_bits;
	logic              esp = 0, prs = 0, fwd = 0, cc_override = 0, tx_valid = 0;
	logic [3:0]        cc_user = 4'h0, cc_out;
	logic              ser_tfg, ser_tc, tx_busy, rx_valid, pix_valid;
	logic [7:0]        tx_data = 8'h00, rx_data, b;
	clfr_pix_s         pix_word, last;
	logic [CNT_W-1:0]  line_pixels, frame_lines;
	int                errors = 0, n_tests = 0, n_pix, n_rx, n_sof;
	// Clocks, unrelated in phase
	always #5 clock = ~clock;
	initial begin
		#33;
		forever #80 pix_clock = ~pix_clock;
	end
	clfr_receiver #(.DIV(8)) dut (.clock(clock), .rst_n(rst_n), .ce(ce), .cfg(cfg),
		.pix_clock(pix_clock), .link_bits(link_bits), .exposure_sync_pulse(esp),
		.pixel_reset_signal(prs), .forward_dir(fwd), .cc_override(cc_override),
		.cc_user(cc_user), .cc_out(cc_out), .ser_tfg(ser_tfg), .ser_tc(ser_tc),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_busy(tx_busy), .rx_valid(rx_valid),
		.rx_data(rx_data), .pix_valid(pix_valid), .pix_word(pix_word),
		.line_pixels(line_pixels), .frame_lines(frame_lines));
	clfr_camera #(.BIT_NS(80)) cam (.pix_clock(pix_clock), .link_bits(link_bits),
		.ser_tc(ser_tc), .ser_tfg(ser_tfg));
	// Count captured words and received characters
	always @(negedge clock) begin
		if (pix_valid) begin
			n_pix++;
			last = pix_word;
		end
		if (pix_valid && pix_word.sof) n_sof++;
		if (rx_valid) n_rx++;
	end
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wrap_up;
		$display("checks=%0d mismatches=%0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up
	task automatic t_cc;
		check(64'(cc_out), 64'h8);
		check(64'(ser_tc), 64'h1);
		@(negedge clock) {esp, prs, fwd} = 3'b101;
		repeat (2) @(negedge clock);
		check(64'(cc_out), 64'hD);
		{esp, prs, fwd} = 3'b010;
		repeat (2) @(negedge clock);
		check(64'(cc_out), 64'hA);
		{cc_override, cc_user} = 5'h15;
		repeat (2) @(negedge clock);
		check(64'(cc_out), 64'h5);
		cc_override = 1'b0;
		ce = 1'b0; // Frozen: release of the override must not show yet
		{esp, prs, fwd} = 3'b111;
		repeat (2) @(negedge clock);
		check(64'(cc_out), 64'h5);
		ce = 1'b1;
		repeat (2) @(negedge clock);
		check(64'(cc_out), 64'hF);
		$display("camera control test done");
	endtask : t_cc
	task automatic t_pix;
		logic [23:0] px;
		px = 24'h405061;
		for (int c = 0; c < 3; c++) begin
			@(negedge clock) cfg = clfr_cfg_e'(c);
			n_pix = 0;
			n_sof = 0;
			cam.beat(4'h0, 24'h000000);
			cam.line(2, 24'h102030);
			cam.line(2, 24'h405060);
			repeat (4) cam.beat(4'h0, 24'h000000);
			repeat (10) @(negedge clock);
			check(64'(n_pix), 64'h4);
			check(last.pix, c == 0 ? {40'h0, px} : c == 1 ? {16'h0, px, px}
				: {px[15:0], px, px});
			check(64'(n_sof), 64'h1);
			check({last.x, last.y}, 64'h00010001);
			check({line_pixels, frame_lines}, 64'h00020002);
		end
		$display("pixel capture test done");
	endtask : t_pix
	task automatic t_ser;
		fork
			cam.recv(b);
			begin
				@(negedge clock) {tx_valid, tx_data} = 9'h1A5;
				@(negedge clock) tx_valid = 1'b0;
				repeat (20) @(negedge clock);
				{tx_valid, tx_data} = 9'h1FF; // Busy: this request is ignored
				@(negedge clock) tx_valid = 1'b0;
			end
		join
		repeat (20) @(negedge clock);
		check(64'(b), 64'hA5);
		check({tx_busy, ser_tc}, 64'h1);
		n_rx = 0;
		cam.send(8'h3C);
		repeat (40) @(negedge clock);
		check(64'(n_rx), 64'h1);
		check(64'(rx_data), 64'h3C);
		$display("serial test done");
	endtask : t_ser
	// Watchdog against a hang
	initial begin
		#200000;
		errors++;
		wrap_up();
	end
	// Main sequence
	initial begin
		#1 rst_n = 1'b0; // Clean falling edge so every async reset fires
		repeat (6) @(negedge clock);
		rst_n = 1'b1;
		repeat (2) @(negedge clock);
		t_cc();
		repeat (5) @(negedge pix_clock);
		t_pix();
		t_ser();
		wrap_up();
	end
endmodule : camlink_frame_receiver_bench
